/* pkg/chop_pkg.sv */
/*
 * Shared constants for the stepper chopper and protection block.
 * Assumes a 25 MHz core clock and an RC oscillator sampled as a pin.
 */
package chop_pkg;
    localparam int unsigned CORE_CLK_KHZ      = 25000;
    localparam int unsigned OSC_NOM_KHZ       = 1600;
    localparam int unsigned CHOP_NOM_KHZ      = 100;
    localparam int unsigned OSC_PER_CHOP      = 16;
    // Phase whose closing oscillator edge hands slow decay over to fast decay.
    localparam int unsigned FAST_START_PHASE  = 11;
    localparam int unsigned BLANK_MIN_NS      = 450;
    localparam int unsigned BLANK_TYP_NS      = 700;
    localparam int unsigned BLANK_MAX_NS      = 950;
    localparam int unsigned CLK_PERIOD_NS     = 1000000 / CORE_CLK_KHZ;
    // Typical blanking time rounded up to whole cycles.
    localparam int unsigned BLANK_CYCLES      =
        (BLANK_TYP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned OC_MASK_OSC       = 4;
    localparam int unsigned OC_SHUTDOWN_OSC   = 8;
    localparam int unsigned PHASE_W           = 4;
    localparam int unsigned BLANK_W           = 5;
    localparam int unsigned OC_W              = 3;
    // Switch vector bit positions.
    localparam int unsigned SW_HS1            = 3;
    localparam int unsigned SW_HS2            = 2;
    localparam int unsigned SW_LS1            = 1;
    localparam int unsigned SW_LS2            = 0;
    localparam logic [3:0]  SW_OFF            = 4'h0;
    localparam logic [3:0]  SW_FWD_CHARGE     = 4'h9;
    localparam logic [3:0]  SW_FWD_FAST       = 4'h6;
    localparam logic [3:0]  SW_REV_CHARGE     = 4'h6;
    localparam logic [3:0]  SW_REV_FAST       = 4'h9;
    localparam logic [3:0]  SW_SLOW           = 4'h3;

    typedef enum logic [3:0] {
        BR_OFF    = 4'b0001,
        BR_CHARGE = 4'b0010,
        BR_SLOW   = 4'b0100,
        BR_FAST   = 4'b1000
    } bridge_e;
endpackage

/* src/winding_chopper.sv */
/*
 * Per-winding chopper: picks charge, slow or fast decay and blanks sensing.
 * Assumes the limit and zero-current inputs are already synchronised and that
 * period and fast-start strobes are single-cycle pulses from the parent.
 */
`timescale 1ns/1ps
module winding_chopper (
    input  wire logic       core_clk,     // Core clock
    input  wire logic       rst_n,        // Synchronous reset, active low
    input  wire logic       clk_en,       // Freezes state while low
    input  wire logic       run,          // Drive allowed, no fault or standby
    input  wire logic       dir_reverse,  // Winding current direction
    input  wire logic       period_start, // Chopping period starts
    input  wire logic       fast_start,   // Point where slow decay becomes fast
    input  wire logic       limit_hit,    // Sensed current at the set value
    input  wire logic       zero_current, // Winding current decayed to zero
    output logic [3:0]      switches      // high_side_one, two, low_side_one, two
);
    typedef struct packed {
        chop_pkg::bridge_e                 mode;
        logic [chop_pkg::BLANK_W-1:0]      blank;
        logic [3:0]                        sw;
    } state_s;

    state_s st_reg;
    state_s st_next;

    function automatic logic [3:0] sw_of(input chop_pkg::bridge_e m, input logic rev);
        unique case (m)
            chop_pkg::BR_CHARGE: sw_of = rev ? chop_pkg::SW_REV_CHARGE : chop_pkg::SW_FWD_CHARGE;
            chop_pkg::BR_SLOW:   sw_of = chop_pkg::SW_SLOW;
            chop_pkg::BR_FAST:   sw_of = rev ? chop_pkg::SW_REV_FAST : chop_pkg::SW_FWD_FAST;
            default:             sw_of = chop_pkg::SW_OFF;
        endcase
    endfunction

    always_comb begin
        st_next = st_reg;
        if (st_reg.blank != '0) begin
            st_next.blank = st_reg.blank - 1'b1;
        end
        if (!run) begin
            st_next.mode  = chop_pkg::BR_OFF;
            st_next.blank = '0;
        end else begin
            unique case (st_reg.mode)
                chop_pkg::BR_OFF: begin
                    if (period_start) begin
                        st_next.mode = chop_pkg::BR_CHARGE;
                    end
                end
                chop_pkg::BR_CHARGE: begin
                    if (limit_hit && st_reg.blank == '0) begin
                        st_next.mode = chop_pkg::BR_SLOW;
                    end else if (fast_start) begin
                        st_next.mode = chop_pkg::BR_SLOW;
                    end
                end
                chop_pkg::BR_SLOW: begin
                    if (zero_current && st_reg.blank == '0) begin
                        st_next.mode = chop_pkg::BR_OFF;
                    end else if (fast_start) begin
                        st_next.mode = chop_pkg::BR_FAST;
                    end
                end
                chop_pkg::BR_FAST: begin
                    if (zero_current && st_reg.blank == '0) begin
                        st_next.mode = chop_pkg::BR_OFF;
                    end
                end
                default: st_next.mode = chop_pkg::BR_OFF;
            endcase
            if (period_start) begin
                st_next.mode = chop_pkg::BR_CHARGE;
            end
        end
        if (st_next.mode != st_reg.mode && st_next.mode != chop_pkg::BR_OFF) begin
            st_next.blank = chop_pkg::BLANK_W'(chop_pkg::BLANK_CYCLES);
        end
        st_next.sw = sw_of(st_next.mode, dir_reverse);
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st_reg <= '{mode: chop_pkg::BR_OFF, blank: '0, sw: chop_pkg::SW_OFF};
        end else if (clk_en) begin
            st_reg <= st_next;
        end
    end

    assign switches = st_reg.sw;
endmodule

/* src/stepper_chopper_protection.sv */
/*
 * Two-winding chopper with thermal and overcurrent shutdown latches.
 * Assumes the RC oscillator, comparators and mode pins arrive asynchronously;
 * every one passes a two-stage synchroniser before use.
 */
`timescale 1ns/1ps
// Functional notes
// - Over-temperature forces all switches off and latches until released.
// - Thermal latch clears only on reset or all step-mode selects low.
// - Overcurrent must persist four oscillator cycles before tripping.
// - Overcurrent trip turns switches off, latched until standby or reset.
// - While overcurrent latched, behave as standby with outputs inactive.
// - Overcurrent shutdown completes within eight oscillator cycles.
// - Forward current switch patterns for charge, slow and fast decay.
// - Reverse current switch patterns for charge, slow and fast decay.
// - Bridge state selection is autonomous, without host involvement.
// - Ignore current limit for about 700 ns after each switching.
// - Charge ends when sensed current reaches the set value.
// - Zero current during decay puts the bridge all off.
// - Chopping timing comes from the RC oscillator, 1600 kHz gives 100 kHz.
// - Chopping period is sixteen oscillator clocks.
module stepper_chopper_protection (
    input  wire logic       core_clk,          // Core clock, 25 MHz
    input  wire logic       rst_n,             // Synchronous reset, active low
    input  wire logic       clk_en,            // Freezes all state while low
    input  wire logic       osc_in,            // RC oscillator pin
    input  wire logic [1:0] step_mode_select,  // Step-mode pins, both low is standby
    input  wire logic       over_temp,         // Thermal sensor flag
    input  wire logic       over_current,      // Output short detector
    input  wire logic [1:0] dir_reverse,       // Current direction per winding
    input  wire logic [1:0] limit_hit,         // Current reached set value per winding
    input  wire logic [1:0] zero_current,      // Current decayed to zero per winding
    output logic [3:0]      switches_a,        // Winding A switch drive
    output logic [3:0]      switches_b,        // Winding B switch drive
    output logic            thermal_fault_latch,     // Thermal shutdown active
    output logic            overcurrent_fault_latch, // Overcurrent shutdown active
    output logic            standby                  // Outputs held inactive
);
    typedef struct packed {
        logic [1:0]                   osc_sync;
        logic                         osc_prev;
        logic [3:0]                   mode0_sync;
        logic [1:0]                   ot_sync;
        logic [1:0]                   oc_sync;
        logic [3:0]                   dir_sync;
        logic [3:0]                   lim_sync;
        logic [3:0]                   zero_sync;
        logic [chop_pkg::PHASE_W-1:0] phase;
        logic [chop_pkg::OC_W-1:0]    oc_count;
        logic                         period_start;
        logic                         fast_start;
        logic                         thermal;
        logic                         overcurrent;
    } state_s;

    state_s st_reg;
    state_s st_next;
    logic   osc_rise;
    logic   select_all_low;
    logic   run;
    logic [3:0] sw_a;
    logic [3:0] sw_b;

    // The second stage of each synchroniser is the only one read by logic.
    assign osc_rise       = st_reg.osc_sync[1] && !st_reg.osc_prev;
    assign select_all_low = (st_reg.mode0_sync[3:2] == 2'h0);
    assign run            = !select_all_low && !st_reg.thermal && !st_reg.overcurrent;

    always_comb begin
        st_next              = st_reg;
        st_next.osc_sync     = {st_reg.osc_sync[0], osc_in};
        st_next.osc_prev     = st_reg.osc_sync[1];
        st_next.mode0_sync   = {st_reg.mode0_sync[1:0], step_mode_select};
        st_next.ot_sync      = {st_reg.ot_sync[0], over_temp};
        st_next.oc_sync      = {st_reg.oc_sync[0], over_current};
        st_next.dir_sync     = {st_reg.dir_sync[1:0], dir_reverse};
        st_next.lim_sync     = {st_reg.lim_sync[1:0], limit_hit};
        st_next.zero_sync    = {st_reg.zero_sync[1:0], zero_current};
        st_next.period_start = 1'b0;
        st_next.fast_start   = 1'b0;
        if (osc_rise) begin
            st_next.phase = st_reg.phase + 1'b1;
            st_next.period_start = (st_reg.phase == chop_pkg::PHASE_W'(chop_pkg::OSC_PER_CHOP - 1));
            // Fast decay takes the last quarter of the period; mixed decay ratio.
            st_next.fast_start =
                (st_reg.phase == chop_pkg::PHASE_W'(chop_pkg::FAST_START_PHASE));
            if (!st_reg.oc_sync[1]) begin
                st_next.oc_count = '0;
            end else if (st_reg.oc_count != chop_pkg::OC_W'(chop_pkg::OC_MASK_OSC)) begin
                st_next.oc_count = st_reg.oc_count + 1'b1;
            end
        end else if (!st_reg.oc_sync[1]) begin
            st_next.oc_count = '0;
        end
        if (select_all_low) begin
            st_next.thermal     = 1'b0;
            st_next.overcurrent = 1'b0;
        end
        // Set wins over clear, so a thermal fault present in standby stays latched.
        // thermal latch
        if (st_reg.ot_sync[1]) begin
            st_next.thermal = 1'b1;
        end
        if (st_reg.oc_count == chop_pkg::OC_W'(chop_pkg::OC_MASK_OSC)) begin
            st_next.overcurrent = 1'b1;
            st_next.oc_count    = '0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else if (clk_en) begin
            st_reg <= st_next;
        end
    end

    winding_chopper u_winding_a (
        .core_clk     (core_clk),
        .rst_n        (rst_n),
        .clk_en       (clk_en),
        .run          (run),
        .dir_reverse  (st_reg.dir_sync[2]),
        .period_start (st_reg.period_start),
        .fast_start   (st_reg.fast_start),
        .limit_hit    (st_reg.lim_sync[2]),
        .zero_current (st_reg.zero_sync[2]),
        .switches     (sw_a)
    );

    winding_chopper u_winding_b (
        .core_clk     (core_clk),
        .rst_n        (rst_n),
        .clk_en       (clk_en),
        .run          (run),
        .dir_reverse  (st_reg.dir_sync[3]),
        .period_start (st_reg.period_start),
        .fast_start   (st_reg.fast_start),
        .limit_hit    (st_reg.lim_sync[3]),
        .zero_current (st_reg.zero_sync[3]),
        .switches     (sw_b)
    );

    assign switches_a              = run ? sw_a : chop_pkg::SW_OFF;
    assign switches_b              = run ? sw_b : chop_pkg::SW_OFF;
    assign thermal_fault_latch     = st_reg.thermal;
    assign overcurrent_fault_latch = st_reg.overcurrent;
    assign standby                 = !run;
endmodule

/* testbench/chop_sva.sv */
/*
 * Port checks for the chopper and protection block.
 * Assumes an oscillator of sixteen core clocks and that clk_en is only
 * dropped while every input is quiet.
 */
`timescale 1ns/1ps
module chop_sva (
    input wire logic       core_clk,                // Clock
    input wire logic       rst_n,                   // Reset, active low
    input wire logic [1:0] step_mode_select,        // Mode pins
    input wire logic       over_temp,               // Heat flag
    input wire logic       over_current,            // Short flag
    input wire logic [3:0] switches_a,              // Drive A
    input wire logic [3:0] switches_b,              // Drive B
    input wire logic       thermal_fault_latch,     // Heat latch
    input wire logic       overcurrent_fault_latch, // Short latch
    input wire logic       standby                  // Forced off
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    sequence s_heat;
        over_temp[*5];
    endsequence
    sequence s_mode_on;
        (step_mode_select != 2'h0)[*4];
    endsequence
    sequence s_idle;
        (step_mode_select == 2'h0 && !over_temp && !over_current)[*6];
    endsequence
    a_thermal_sets: assert property (s_heat |-> thermal_fault_latch)
        else $error("heat latch not set");
    a_thermal_holds: assert property (s_mode_on ##0 thermal_fault_latch |=> thermal_fault_latch)
        else $error("heat latch lost");
    a_idle_clears: assert property (s_idle |-> !thermal_fault_latch && !overcurrent_fault_latch)
        else $error("latch not cleared");
    a_oc_masked: assert property ($rose(overcurrent_fault_latch) |-> $past(over_current, 40))
        else $error("short trip too early");
    a_oc_deadline: assert property (
        $rose(over_current) |-> ##[1:130] (overcurrent_fault_latch || !over_current))
        else $error("short trip too late");
    a_oc_standby: assert property (overcurrent_fault_latch |-> standby)
        else $error("short latch without standby");
    a_outputs_quiet: assert property (
        (standby || thermal_fault_latch) |-> {switches_a, switches_b} == 8'h00)
        else $error("switches on while off");
    a_blank_hold: assert property (
        ($past(switches_a) == 4'h0 && switches_a != 4'h0)
        |=> ($stable(switches_a) || switches_a == 4'h0)[*8])
        else $error("left charge inside blank");
endmodule
bind stepper_chopper_protection chop_sva u_chop_sva (
    .core_clk(core_clk), .rst_n(rst_n), .step_mode_select(step_mode_select),
    .over_temp(over_temp), .over_current(over_current), .switches_a(switches_a),
    .switches_b(switches_b), .thermal_fault_latch(thermal_fault_latch),
    .overcurrent_fault_latch(overcurrent_fault_latch), .standby(standby));

/* testbench/winding_model.sv */
/*
 * Behavioural winding: current rises in charge and falls in decay.
 * Assumes direction changes only while the bridge is off.
 */
`timescale 1ns/1ps
module winding_model #(
    parameter int LIMIT = 60 // Set current in steps
) (
    input  wire logic       core_clk,    // Clock
    input  wire logic       dir_reverse, // Direction
    input  wire logic       spike,       // Early limit
    input  wire logic [3:0] switches,    // Bridge drive
    output logic            limit_hit,   // At set current
    output logic            zero_current // At zero
);
    logic [7:0] mag_reg  = 8'h00;
    logic [2:0] slow_reg = 3'h0;
    // Reversal through zero is not modelled; the magnitude stops at zero.
    always @(negedge core_clk) begin
        slow_reg <= slow_reg + 3'h1;
        if (switches == (dir_reverse ? 4'h6 : 4'h9)) begin
            mag_reg <= mag_reg + 8'(mag_reg != 8'hff);
        end else if (switches == 4'h3) begin
            mag_reg <= mag_reg - 8'(slow_reg == 3'h0 && mag_reg != 8'h00);
        end else begin
            mag_reg <= (mag_reg > 8'h01) ? mag_reg - 8'h02 : 8'h00;
        end
    end
    assign limit_hit    = spike || (mag_reg >= 8'(LIMIT));
    assign zero_current = (mag_reg == 8'h00);
endmodule

/* testbench/tb_top.sv */
/*
 * Self-checking bench for the chopper and protection block.
 * Assumes two winding models answer the bridge; clk_en drops only in the
 * freeze test, while every input is quiet.
 */
`timescale 1ns/1ps
module tb_top;
    localparam int OSC_CLKS = 16;
    localparam int BLANK_LO = chop_pkg::BLANK_MIN_NS / chop_pkg::CLK_PERIOD_NS;
    // Upper bound allows for the two-stage limit synchroniser.
    localparam int BLANK_HI = chop_pkg::BLANK_MAX_NS / chop_pkg::CLK_PERIOD_NS + 4;
    typedef struct {
        logic [1:0] dir;
        logic [7:0] charge;
        logic [7:0] fast;
    } row_s;
    row_s        rows [4] = '{'{2'h0, 8'h99, 8'h66}, '{2'h1, 8'h69, 8'h96},
                              '{2'h2, 8'h96, 8'h69}, '{2'h3, 8'h66, 8'h99}};
    logic        core_clk = 1'b0, rst_n = 1'b0, spike = 1'b0, clk_en = 1'b1;
    logic        over_temp = 1'b0, over_current = 1'b0;
    logic        thermal_fault_latch, overcurrent_fault_latch, standby;
    logic [1:0]  step_mode_select = 2'h0, dir_reverse = 2'h0, limit_hit, zero_current;
    logic [3:0]  osc_cnt = 4'h0, switches_a, switches_b;
    logic [15:0] state_w;
    int          n_errors = 0, samples_checked = 0, n = 0, cyc = 0, last = 0;

    assign state_w = {3'h0, switches_a, switches_b, 2'h0, thermal_fault_latch,
                      overcurrent_fault_latch, standby};
    stepper_chopper_protection u_stepper_chopper_protection (
        .core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .osc_in(osc_cnt[3]),
        .step_mode_select(step_mode_select), .over_temp(over_temp),
        .over_current(over_current), .dir_reverse(dir_reverse), .limit_hit(limit_hit),
        .zero_current(zero_current), .switches_a(switches_a), .switches_b(switches_b),
        .thermal_fault_latch(thermal_fault_latch),
        .overcurrent_fault_latch(overcurrent_fault_latch), .standby(standby));
    winding_model u_motor_a (.core_clk(core_clk), .dir_reverse(dir_reverse[0]), .spike(spike),
        .switches(switches_a), .limit_hit(limit_hit[0]), .zero_current(zero_current[0]));
    winding_model u_motor_b (.core_clk(core_clk), .dir_reverse(dir_reverse[1]), .spike(spike),
        .switches(switches_b), .limit_hit(limit_hit[1]), .zero_current(zero_current[1]));

    initial begin
        forever #20 core_clk = ~core_clk;
    end
    always @(negedge core_clk) osc_cnt <= osc_cnt + 4'h1;
    always @(posedge core_clk) cyc <= cyc + 1;

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wait_sw(input logic [7:0] target, input int limit);
        n = 0;
        while (state_w[12:5] !== target && n < limit) begin
            @(negedge core_clk);
            n++;
        end
        check("switches", {8'h00, target}, {8'h00, state_w[12:5]});
    endtask
    task automatic end_of_test();
        if (n_errors == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        // Mode pins stay low through power-up so the motor cannot start.
        repeat (12) @(negedge core_clk);
        rst_n = 1'b1;
        check("reset", 16'h0001, state_w);
        repeat (300) @(negedge core_clk);
        check("standby", 16'h0001, state_w);
        step_mode_select = 2'h1;
        foreach (rows[i]) begin
            dir_reverse = rows[i].dir;
            wait_sw(rows[i].charge, 600);
            if (i > 0) begin
                check("period", 16'(OSC_CLKS * chop_pkg::OSC_PER_CHOP), 16'(cyc - last));
            end
            last = cyc;
            wait_sw(8'h33, 200);
            wait_sw(rows[i].fast, 200);
            wait_sw(8'h00, 100);
        end
        spike = 1'b1;
        wait_sw(8'h66, 300);
        wait_sw(8'h33, 40);
        spike = 1'b0;
        check("blank", 16'h0001, 16'(n >= BLANK_LO && n <= BLANK_HI));
        // The short charge lets slow decay reach zero before the fast point.
        wait_sw(8'h00, 168);
        wait_sw(8'h66, 600);
        over_temp = 1'b1;
        repeat (6) @(negedge core_clk);
        check("thermal", 16'h0004, state_w & 16'hfffe);
        over_temp = 1'b0;
        repeat (300) @(negedge core_clk);
        check("thermal hold", 16'h0004, state_w & 16'hfffe);
        step_mode_select = 2'h0;
        repeat (8) @(negedge core_clk);
        check("thermal clear", 16'h0001, state_w);
        step_mode_select = 2'h2;
        over_current = 1'b1;
        repeat (2 * OSC_CLKS) @(negedge core_clk);
        over_current = 1'b0;
        repeat (20) @(negedge core_clk);
        check("short masked", 16'h0000, state_w & 16'h0002);
        over_current = 1'b1;
        repeat (8 * OSC_CLKS) @(negedge core_clk);
        check("short trip", 16'h0003, state_w);
        over_current = 1'b0;
        repeat (100) @(negedge core_clk);
        check("short hold", 16'h0003, state_w);
        step_mode_select = 2'h0;
        repeat (8) @(negedge core_clk);
        check("short clear", 16'h0001, state_w);
        step_mode_select = 2'h3;
        wait_sw(8'h66, 600);
        over_temp = 1'b1;
        repeat (6) @(negedge core_clk);
        check("thermal again", 16'h0004, state_w & 16'hfffe);
        over_temp = 1'b0;
        rst_n     = 1'b0;
        repeat (2) @(negedge core_clk);
        rst_n = 1'b1;
        check("reset clear", 16'h0001, state_w);
        repeat (4) @(negedge core_clk);
        check("restart", 16'h0000, state_w);
        clk_en = 1'b0;
        repeat (300) @(negedge core_clk);
        check("freeze", 16'h0000, state_w);
        clk_en = 1'b1;
        wait_sw(8'h66, 600);
        end_of_test();
    end

    initial begin
        #800000;
        n_errors++;
        $display("mismatch watchdog expected done seen running");
        end_of_test();
    end
endmodule
